/* File: dv/card_bridge_checker.sv */
`timescale 1ns/1ps
`include "card_bridge_regs.svh"
module card_bridge_checker
    import card_bridge_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // host pins
    input wire logic pciRstB,
    input wire logic hw_suspend_n,
    // register port
    input wire reg_req_type regReq,
    input wire logic [31:0] regRdData,
    // card side
    input wire logic cardPresent,
    input wire logic cardIsCardBus,
    input wire logic cclkrunIn,
    input wire card_pins_type cardPins,
    // status
    input wire logic pciIfEnable,
    input wire logic intOut
);
    pm_state_type pmShadow;
    logic pmWrite;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // =====================================================
    // power state as software last set it, back to D0 on global or bus reset
    assign pmWrite = regReq.wr && regReq.cfg && regReq.addr == `PM_CSR_OFS && pciIfEnable;
    always_ff @(posedge ref_clk) begin
        if (!rst_b || (!pciRstB && hw_suspend_n)) begin
            pmShadow <= `PM_D0;
        end else if (pmWrite) begin
            pmShadow <= regReq.data[1:0];
        end
    end
    sequence d3Exit;
        pmWrite && regReq.data[1:0] == `PM_D0 && pmShadow == `PM_D3;
    endsequence
    // =====================================================
    // properties
    AST_RD_IDLE: assert property (!$past(regReq.rd) |-> regRdData == 32'h0)
        else $error("read data outside answer cycle");
    AST_SOCK_REFUSE: assert property (regReq.rd && !regReq.cfg && pmShadow != `PM_D0 |=> regRdData == 32'h0)
        else $error("socket read answered outside D0");
    AST_INT_OFF: assert property (pmShadow != `PM_D0 && $past(pmShadow) != `PM_D0 |-> !intOut)
        else $error("interrupt outside D0");
    AST_D3_STOP: assert property (pmWrite && regReq.data[1:0] == `PM_D3 && cardPresent && cardIsCardBus
        |-> ##2 !cardPins.clkEnable && !cardPins.resetB)
        else $error("D3 entry left card clock or reset");
    AST_D3_EXIT_OFF: assert property (d3Exit |-> ##2 !pciIfEnable [*8])
        else $error("bus on during internal reset");
    AST_D3_EXIT_BACK: assert property (d3Exit |-> ##[12:24] pciIfEnable)
        else $error("bus not back after internal reset");
    AST_HW_OFF: assert property (!hw_suspend_n [*4] |-> !pciIfEnable)
        else $error("bus on during hardware suspend");
    AST_HW_SYNC: assert property ($fell(hw_suspend_n) && pciIfEnable |=> pciIfEnable)
        else $error("suspend gated bus without synchroniser");
    AST_D2_STOP: assert property ((pmShadow == `PM_D2 && cclkrunIn) [*5] |-> !cardPins.clkEnable)
        else $error("card clock runs after D2 handshake");
    AST_SUSP_LEVELS: assert property ($fell(cardPins.clkEnable) && pmShadow != `PM_D0
        && $past(cardPresent) && $past(cardIsCardBus)
        |-> cardPins.parLow && cardPins.grantHigh && cardPins.restLevels)
        else $error("card levels wrong at clock stop");
    CVR_D3_EXIT: cover property (d3Exit);
    CVR_D2_STOP: cover property ($fell(cardPins.clkEnable) && pmShadow == `PM_D2);
    CVR_HW: cover property ($fell(pciIfEnable) && !hw_suspend_n);
endmodule

bind card_bridge_reset_power_control card_bridge_checker u_card_bridge_checker (
    .ref_clk(ref_clk), .rst_b(rst_b), .pciRstB(pciRstB), .hw_suspend_n(hw_suspend_n),
    .regReq(regReq), .regRdData(regRdData), .cardPresent(cardPresent),
    .cardIsCardBus(cardIsCardBus), .cclkrunIn(cclkrunIn), .cardPins(cardPins),
    .pciIfEnable(pciIfEnable), .intOut(intOut)
);

/* File: dv/card_bridge_reset_power_control_tb_top.sv */
`timescale 1ns/1ps
`include "card_bridge_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failCount++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module card_bridge_reset_power_control_tb_top
    import card_bridge_pkg::*;
;
    logic ref_clk = 1'b0, clkOn = 1'b1, rst_b = 1'b0, pciRstB = 1'b0, hw_suspend_n = 1'b0;
    logic auxPower = 1'b0, cardPresent = 1'b0, cardIsCardBus = 1'b0, cardStsChg = 1'b0;
    logic linkOn = 1'b0, slowStop = 1'b0;
    logic cclkrunIn, cclkrunOut, cclkrunOe, pciIfEnable, intOut, pmeOut, pmeOe;
    logic [2:0] flashDetect = 3'h0;
    logic [31:0] regRdData;
    reg_req_type regReq = '0;
    card_pins_type cardPins;
    int failCount = 0, checked = 0, cycles = 0, n;

    always #12.5 ref_clk = clkOn ? ~ref_clk : ref_clk;

    card_bridge_reset_power_control u_card_bridge_reset_power_control (
        .ref_clk(ref_clk), .rst_b(rst_b), .pciRstB(pciRstB), .hw_suspend_n(hw_suspend_n),
        .auxPower(auxPower), .regReq(regReq), .regRdData(regRdData), .cardPresent(cardPresent),
        .cardIsCardBus(cardIsCardBus), .cardVoltSense(2'h1), .cardStsChg(cardStsChg),
        .cclkrunIn(cclkrunIn), .cclkrunOut(cclkrunOut), .cclkrunOe(cclkrunOe), .cardPins(cardPins),
        .linkOn(linkOn), .flashDetect(flashDetect), .pciIfEnable(pciIfEnable), .intOut(intOut),
        .pmeOut(pmeOut), .pmeOe(pmeOe)
    );
    card_clkrun_model u_card_clkrun_model (
        .ref_clk(ref_clk), .cclkrunOe(cclkrunOe), .slowStop(slowStop), .cclkrunIn(cclkrunIn)
    );

    // =====================================================
    // bench tasks
    task summarize;
        $display("checked %0d failCount %0d", checked, failCount);
        if (failCount == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task wreg(input logic c, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regReq <= '{addr: a, cfg: c, wr: 1'b1, rd: 1'b0, data: d};
        @(posedge ref_clk);
        regReq <= '0;
    endtask
    task rreg(input logic c, input logic [11:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        regReq <= '{addr: a, cfg: c, wr: 1'b0, rd: 1'b1, data: 32'h0};
        @(posedge ref_clk);
        regReq <= '0;
        #1 `CHK(regRdData, e)
    endtask
    task waitBus;
        n = 0;
        while (pciIfEnable !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        `CHK(pciIfEnable, 1'b1)
    endtask
    task busRst;
        tick(1);
        pciRstB <= 1'b0;
        tick(2);
        pciRstB <= 1'b1;
        waitBus();
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            summarize();
        end
    end

    // =====================================================
    // tests
    initial begin
        tick(4);
        rst_b <= 1'b1;
        tick(4);
        hw_suspend_n <= 1'b1;
        tick(4000);
        pciRstB <= 1'b1;
        waitBus();
        rreg(1, `PM_CSR_OFS, 32'h0);
        rreg(1, `PM_CAP_OFS, 32'hFE02);
        rreg(1, `WAKE_TRIGGER_OFS, 32'hF);
        rreg(1, 12'h0FC, 32'h0);
        rreg(0, `SOCK_CONTROL_OFS, 32'h0);
        wreg(1, `SUBSYS_IDS_OFS, 32'h12345678);
        wreg(1, `WAKE_TRIGGER_OFS, 32'h5);
        wreg(0, `SOCK_MASK_OFS, 32'hF);
        busRst();
        rreg(1, `SUBSYS_IDS_OFS, 32'h12345678);
        rreg(1, `WAKE_TRIGGER_OFS, 32'h5);
        rreg(0, `SOCK_MASK_OFS, 32'h0);
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        waitBus();
        rreg(1, `SUBSYS_IDS_OFS, 32'h0);
        rreg(1, `WAKE_TRIGGER_OFS, 32'hF);
        $display("test resets done");
        for (int en = 1; en >= 0; en--) begin
            wreg(0, `SOCK_MASK_OFS, 32'hF);
            wreg(0, `MISC_ONE_OFS, 32'h1);
            wreg(0, `CARD_POWER_OFS, 32'hFC);
            wreg(0, `STATUS_CFG_OFS, 32'hF);
            wreg(1, `PM_CAP_OFS, 32'h0);
            wreg(1, `PM_CSR_OFS, en ? 32'h103 : 32'h3);
            busRst();
            rreg(1, `PM_CSR_OFS, en ? 32'h100 : 32'h0);
            rreg(1, `PM_CAP_OFS, en ? 32'h7E02 : 32'hFE02);
            rreg(0, `SOCK_MASK_OFS, en ? 32'hF : 32'h0);
            rreg(0, `MISC_ONE_OFS, en ? 32'h1 : 32'h0);
            rreg(0, `CARD_POWER_OFS, en ? 32'hFC : 32'h0);
            rreg(0, `STATUS_CFG_OFS, en ? 32'hF : 32'h0);
        end
        $display("test wake_context done");
        cardPresent <= 1'b1;
        cardIsCardBus <= 1'b1;
        wreg(0, `SOCK_MASK_OFS, 32'hF);
        wreg(0, `SOCK_CONTROL_OFS, 32'h1);
        wreg(1, `PM_CSR_OFS, 32'h3);
        tick(2);
        `CHK(cardPins, 5'b01011)
        rreg(0, `SOCK_MASK_OFS, 32'h0);
        rreg(1, `PM_CSR_OFS, 32'h8003);
        wreg(1, `PM_CSR_OFS, 32'h8000);
        tick(1);
        n = 0;
        while (pciIfEnable !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        `CHK(n > 12 && n < 18, 1'b1)
        rreg(0, `SOCK_CONTROL_OFS, 32'h0);
        rreg(0, `SOCK_MASK_OFS, 32'hF);
        $display("test d3_cycle done");
        wreg(0, `STATUS_CFG_OFS, 32'h8);
        for (int i = 0; i < 5; i++) begin
            wreg(1, `PM_CSR_OFS, 32'h8100);
            tick(1);
            `CHK(pmeOe, 1'b0)
            if (i == 0) cardPresent <= 1'b0;
            else if (i == 1) linkOn <= 1'b1;
            else flashDetect <= flashDetect ^ (3'h1 << (i - 2));
            tick(1);
            linkOn <= 1'b0;
            tick(2);
            `CHK(pmeOe, 1'b1)
            rreg(1, `PM_CSR_OFS, 32'h8100);
        end
        `CHK(intOut, 1'b1)
        $display("test wake_events done");
        cardPresent <= 1'b1;
        tick(3);
        wreg(1, `PM_CSR_OFS, 32'h8101);
        tick(4);
        `CHK(cardPins.clkEnable, 1'b1)
        `CHK(intOut, 1'b0)
        slowStop <= 1'b1;
        wreg(1, `PM_CSR_OFS, 32'h102);
        tick(4);
        `CHK(cardPins.clkEnable, 1'b1)
        n = 0;
        while (cardPins.clkEnable !== 1'b0 && n < 30) begin
            tick(1);
            n++;
        end
        `CHK(cardPins, 5'b01111)
        `CHK({cclkrunOe, cclkrunOut}, 2'b00)
        slowStop <= 1'b0;
        wreg(1, `PM_CSR_OFS, 32'h100);
        $display("test clock_stop done");
        wreg(1, `PM_CAP_OFS, 32'h8000);
        wreg(1, `PM_CSR_OFS, 32'h8103);
        auxPower <= 1'b1;
        tick(2);
        `CHK(pmeOe, 1'b0)
        `CHK(pmeOut, 1'b0)
        @(negedge ref_clk);
        clkOn = 1'b0;
        cardStsChg = 1'b1;
        #100 `CHK(pmeOe, 1'b1)
        cardStsChg = 1'b0;
        clkOn = 1'b1;
        tick(2);
        auxPower <= 1'b0;
        wreg(1, `PM_CSR_OFS, 32'h8000);
        tick(3);
        waitBus();
        $display("test aux_wake done");
        wreg(0, `SOCK_MASK_OFS, 32'h5);
        hw_suspend_n <= 1'b0;
        tick(1);
        `CHK(pciIfEnable, 1'b1)
        tick(4);
        `CHK(pciIfEnable, 1'b0)
        rreg(1, `PM_CSR_OFS, 32'h0);
        pciRstB <= 1'b0;
        tick(3);
        pciRstB <= 1'b1;
        tick(1);
        hw_suspend_n <= 1'b1;
        tick(4);
        waitBus();
        rreg(0, `SOCK_MASK_OFS, 32'h5);
        $display("test hw_suspend done");
        summarize();
    end
endmodule

/* File: dv/card_clkrun_model.sv */
`timescale 1ns/1ps
module card_clkrun_model (
    // clock
    input wire logic ref_clk,
    // bridge drive and bench control
    input wire logic cclkrunOe,
    input wire logic slowStop,
    // wired level of the clock-run line
    output logic cclkrunIn
);
    logic [3:0] holdCount;
    initial holdCount = 4'h0;
    // a slow card keeps the line low for a while after the bridge lets go
    always @(posedge ref_clk) begin
        if (cclkrunOe) begin
            holdCount <= slowStop ? 4'h8 : 4'h0;
        end else if (holdCount != 4'h0) begin
            holdCount <= holdCount - 4'h1;
        end
    end
    // pulled up, low while either party drives it
    assign cclkrunIn = !(cclkrunOe || holdCount != 4'h0);
endmodule

/* File: include/card_bridge_pkg.sv */
package card_bridge_pkg;

    typedef logic [1:0] pm_state_type;

    typedef enum {CLK_RUN, CLK_STOP_REQ, CLK_STOPPED} clk_state_type;

    // register port request, one strobe at a time
    typedef struct packed {
        logic [11:0] addr;
        logic cfg;
        logic wr;
        logic rd;
        logic [31:0] data;
    } reg_req_type;

    // card-side levels held by the bridge
    typedef struct packed {
        logic clkEnable;
        logic parLow;
        logic resetB;
        logic grantHigh;
        logic restLevels;
    } card_pins_type;

endpackage

/* File: include/card_bridge_regs.svh */
`ifndef CARD_BRIDGE_REGS_SVH
`define CARD_BRIDGE_REGS_SVH

// =====================================================================
// socket space offsets (regCfg low)
`define SOCK_EVENT_OFS 12'h000
`define SOCK_MASK_OFS 12'h004
`define SOCK_PRESENT_OFS 12'h008
`define SOCK_CONTROL_OFS 12'h010
`define CARD_POWER_OFS 12'h802
`define STATUS_CHANGE_OFS 12'h804
`define STATUS_CFG_OFS 12'h805
`define MISC_ONE_OFS 12'h82F

// =====================================================================
// configuration space offsets (regCfg high)
`define SUBSYS_IDS_OFS 12'h0C0
`define WAKE_TRIGGER_OFS 12'h0C4
`define PM_CAP_OFS 12'h0DE
`define PM_CSR_OFS 12'h0E0

// =====================================================================
// field positions
`define PM_CAP_WAKE_COLD_BIT 15
`define PM_CSR_WAKE_EN_BIT 8
`define PM_CSR_WAKE_STS_BIT 15
`define SOCK_CTL_CLK_STOP_BIT 0
`define CSC_DETECT_BIT 3
`define CSC_STSCHG_BIT 0

// =====================================================================
// power states
`define PM_D0 2'h0
`define PM_D1 2'h1
`define PM_D2 2'h2
`define PM_D3 2'h3

// =====================================================================
// reset values and counts
`define PM_CAP_RESET 16'hFE02
`define SUBSYS_IDS_RESET 32'h00000000
`define WAKE_TRIGGER_RESET 4'hF
`define INT_RST_CYCLES 5'h10

`endif

/* File: rtl/card_bridge_reset_power_control.sv */
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "card_bridge_regs.svh"

module card_bridge_reset_power_control
    import card_bridge_pkg::*;
(
    // clock and global reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // host pins
    input wire logic pciRstB,
    input wire logic hw_suspend_n,
    input wire logic auxPower,
    // register port
    input wire reg_req_type regReq,
    output logic [31:0] regRdData,
    // card side
    input wire logic cardPresent,
    input wire logic cardIsCardBus,
    input wire logic [1:0] cardVoltSense,
    input wire logic cardStsChg,
    input wire logic cclkrunIn,
    output logic cclkrunOut,
    output logic cclkrunOe,
    output card_pins_type cardPins,
    // other functions
    input wire logic linkOn,
    input wire logic [2:0] flashDetect,
    // status to host
    output logic pciIfEnable,
    output logic intOut,
    output logic pmeOut,
    output logic pmeOe
);

    // =================================================================
    // decode
    function automatic logic hit(input reg_req_type r, input logic cfg, input logic [11:0] ofs);
        hit = (r.cfg == cfg) && (r.addr == ofs);
    endfunction

    function automatic logic [3:0] w1c(input logic [3:0] cur, input logic [3:0] clr, input logic [3:0] set);
        w1c = (cur & ~clr) | set;
    endfunction

    localparam logic [15:0] PM_CAP_VALUE = `PM_CAP_RESET;
    logic hwSpndMeta;
    logic hwSpndSync;
    logic [4:0] intRstCnt;
    pm_state_type pmState;
    logic wakeEn;
    logic wakeSts;
    logic wakeCold;
    logic [31:0] subsysIds;
    logic [3:0] wakeTrigger;
    logic [3:0] sockEvent;
    logic [3:0] sockMask;
    logic [3:0] presentBits;
    logic [6:0] sockCtl;
    logic [7:0] pwrCtl;
    logic [3:0] statusChange;
    logic [3:0] statusCfg;
    logic [7:0] miscOne;
    logic cardPresentQ;
    logic cardStsChgQ;
    logic [2:0] flashDetectQ;
    clk_state_type clkState;

    // =================================================================
    // reset classes
    logic busOn;
    logic busReset;
    logic keepContext;
    logic contextHeld;
    logic contextClear;
    logic leaveD3;
    logic ordinaryClear;
    logic memOk;
    logic cfgWr;
    logic memWr;
    logic anyRd;

    assign busOn = hwSpndSync && (intRstCnt == 5'h00);
    assign busReset = !pciRstB && hwSpndSync;
    assign keepContext = ((pmState == `PM_D3) && wakeEn) || contextHeld;
    assign contextClear = busReset && !keepContext;
    assign memOk = busOn && (pmState == `PM_D0);
    assign cfgWr = regReq.wr && busOn && regReq.cfg;
    assign memWr = regReq.wr && memOk && !regReq.cfg;
    assign anyRd = regReq.rd && (regReq.cfg ? busOn : memOk);
    assign leaveD3 = cfgWr && hit(regReq, 1'b1, `PM_CSR_OFS) && (pmState == `PM_D3)
        && (regReq.data[1:0] == `PM_D0);
    assign ordinaryClear = busReset || leaveD3;

    // keep decision taken as bus reset starts, since bus reset moves the state to D0
    always_ff @(posedge ref_clk) begin
        contextHeld <= rst_b && busReset && keepContext;
    end

    // =================================================================
    // wake sources
    logic detectChange;
    logic stsChgRise;
    logic [2:0] flashChange;
    logic wakeEvent;

    assign detectChange = cardPresent ^ cardPresentQ;
    assign stsChgRise = cardStsChg && !cardStsChgQ && cardPresent;
    assign flashChange = flashDetect ^ flashDetectQ;
    assign wakeEvent = detectChange || stsChgRise
        || (wakeTrigger[0] && linkOn) || |(wakeTrigger[3:1] & flashChange);

    // =================================================================
    // hardware suspend synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            hwSpndMeta <= 1'b0;
            hwSpndSync <= 1'b0;
        end else begin
            hwSpndMeta <= hw_suspend_n;
            hwSpndSync <= hwSpndMeta;
        end
    end

    // =================================================================
    // internal reset after D3hot to D0
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            intRstCnt <= 5'h00;
        end else if (leaveD3) begin
            intRstCnt <= `INT_RST_CYCLES;
        end else if (intRstCnt != 5'h00) begin
            intRstCnt <= intRstCnt - 5'h01;
        end
    end

    // =================================================================
    // edge history, global reset only
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cardPresentQ <= 1'b0;
            cardStsChgQ <= 1'b0;
            flashDetectQ <= 3'h0;
        end else begin
            cardPresentQ <= cardPresent;
            cardStsChgQ <= cardStsChg;
            flashDetectQ <= flashDetect;
        end
    end

    // =================================================================
    // reset-resistant registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            subsysIds <= `SUBSYS_IDS_RESET;
            wakeTrigger <= `WAKE_TRIGGER_RESET;
        end else begin
            if (cfgWr && hit(regReq, 1'b1, `SUBSYS_IDS_OFS)) begin
                subsysIds <= regReq.data;
            end
            if (cfgWr && hit(regReq, 1'b1, `WAKE_TRIGGER_OFS)) begin
                wakeTrigger <= regReq.data[3:0];
            end
        end
    end

    // =================================================================
    // power state
    always_ff @(posedge ref_clk) begin
        if (!rst_b || busReset) begin
            pmState <= `PM_D0;
        end else if (cfgWr && hit(regReq, 1'b1, `PM_CSR_OFS)) begin
            pmState <= regReq.data[1:0];
        end
    end

    // =================================================================
    // wake context: power management bits
    always_ff @(posedge ref_clk) begin
        if (!rst_b || contextClear) begin
            wakeEn <= 1'b0;
            wakeSts <= 1'b0;
            wakeCold <= PM_CAP_VALUE[`PM_CAP_WAKE_COLD_BIT];
        end else begin
            if (cfgWr && hit(regReq, 1'b1, `PM_CSR_OFS)) begin
                wakeEn <= regReq.data[`PM_CSR_WAKE_EN_BIT];
            end
            if (cfgWr && hit(regReq, 1'b1, `PM_CAP_OFS)) begin
                wakeCold <= regReq.data[`PM_CAP_WAKE_COLD_BIT];
            end
            // a new event wins over the clear
            if (wakeEvent) begin
                wakeSts <= 1'b1;
            end else if (cfgWr && hit(regReq, 1'b1, `PM_CSR_OFS) && regReq.data[`PM_CSR_WAKE_STS_BIT]) begin
                wakeSts <= 1'b0;
            end
        end
    end

    // =================================================================
    // wake context: socket event, mask, present state, status change
    always_ff @(posedge ref_clk) begin
        if (!rst_b || contextClear) begin
            sockEvent <= 4'h0;
            sockMask <= 4'h0;
            presentBits <= 4'h0;
            statusChange <= 4'h0;
            statusCfg <= 4'h0;
        end else begin
            sockEvent <= w1c(sockEvent, memWr && hit(regReq, 1'b0, `SOCK_EVENT_OFS) ? regReq.data[3:0] : 4'h0,
                {1'b0, detectChange, detectChange, stsChgRise});
            statusChange <= w1c(statusChange,
                memWr && hit(regReq, 1'b0, `STATUS_CHANGE_OFS) ? regReq.data[3:0] : 4'h0,
                {detectChange, 2'h0, stsChgRise});
            if (memWr && hit(regReq, 1'b0, `SOCK_MASK_OFS)) begin
                sockMask <= regReq.data[3:0];
            end
            if (memWr && hit(regReq, 1'b0, `STATUS_CFG_OFS)) begin
                statusCfg <= regReq.data[3:0];
            end
            if (detectChange) begin
                presentBits <= {cardVoltSense, cardPresent && !cardIsCardBus, cardPresent && cardIsCardBus};
            end
        end
    end

    // =================================================================
    // mixed registers: context fields and ordinary fields
    always_ff @(posedge ref_clk) begin
        if (!rst_b || contextClear) begin
            sockCtl[6:4] <= 3'h0;
            pwrCtl[7:2] <= 6'h00;
            miscOne[0] <= 1'b0;
        end else begin
            if (memWr && hit(regReq, 1'b0, `SOCK_CONTROL_OFS)) begin
                sockCtl[6:4] <= regReq.data[6:4];
            end
            if (memWr && hit(regReq, 1'b0, `CARD_POWER_OFS)) begin
                pwrCtl[7:2] <= regReq.data[7:2];
            end
            if (memWr && hit(regReq, 1'b0, `MISC_ONE_OFS)) begin
                miscOne[0] <= regReq.data[0];
            end
        end
        if (!rst_b || ordinaryClear) begin
            sockCtl[3:0] <= 4'h0;
            pwrCtl[1:0] <= 2'h0;
            miscOne[7:1] <= 7'h00;
        end else begin
            if (memWr && hit(regReq, 1'b0, `SOCK_CONTROL_OFS)) begin
                sockCtl[3:0] <= regReq.data[3:0];
            end
            if (memWr && hit(regReq, 1'b0, `CARD_POWER_OFS)) begin
                pwrCtl[1:0] <= regReq.data[1:0];
            end
            if (memWr && hit(regReq, 1'b0, `MISC_ONE_OFS)) begin
                miscOne[7:1] <= regReq.data[7:1];
            end
        end
    end

    // =================================================================
    // card clock stop handshake
    logic stopWanted;
    logic inD3;

    assign inD3 = pmState == `PM_D3;
    assign stopWanted = (pmState == `PM_D2) || sockCtl[`SOCK_CTL_CLK_STOP_BIT];

    always_ff @(posedge ref_clk) begin
        if (!rst_b || ordinaryClear) begin
            clkState <= CLK_RUN;
        end else begin
            case (clkState)
                CLK_RUN: begin
                    if (inD3) begin
                        clkState <= CLK_STOPPED;
                    end else if (stopWanted) begin
                        clkState <= CLK_STOP_REQ;
                    end
                end
                CLK_STOP_REQ: begin
                    if (inD3 || cclkrunIn) begin
                        clkState <= CLK_STOPPED;
                    end else if (!stopWanted) begin
                        clkState <= CLK_RUN;
                    end
                end
                CLK_STOPPED: begin
                    if (!inD3 && (!stopWanted || !cclkrunIn)) begin
                        clkState <= CLK_RUN;
                    end
                end
                default: begin
                    clkState <= CLK_RUN;
                end
            endcase
        end
    end

    // =================================================================
    // card pin levels
    logic holdLevels;

    assign holdLevels = cardPresent && cardIsCardBus && (inD3 || clkState == CLK_STOPPED);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cardPins <= '{clkEnable: 1'b0, parLow: 1'b0, resetB: 1'b0, grantHigh: 1'b0, restLevels: 1'b0};
            cclkrunOe <= 1'b0;
        end else begin
            cardPins.clkEnable <= !inD3 && (clkState != CLK_STOPPED);
            cardPins.resetB <= !(inD3 && cardPresent && cardIsCardBus);
            cardPins.parLow <= holdLevels;
            cardPins.grantHigh <= holdLevels;
            cardPins.restLevels <= holdLevels;
            cclkrunOe <= clkState == CLK_RUN;
        end
    end

    assign cclkrunOut = 1'b0;

    // =================================================================
    // bus interface, interrupt and wake outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pciIfEnable <= 1'b0;
            intOut <= 1'b0;
        end else begin
            pciIfEnable <= busOn && !leaveD3;
            intOut <= (pmState == `PM_D0)
                && (|(sockEvent & sockMask) || |(statusChange & statusCfg));
        end
    end

    assign pmeOut = 1'b0;
    assign pmeOe = wakeEn && (wakeSts
        || (auxPower && wakeCold && (detectChange || cardStsChg)));

    // =================================================================
    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            regRdData <= 32'h00000000;
        end else if (!anyRd) begin
            regRdData <= 32'h00000000;
        end else if (regReq.cfg) begin
            case (regReq.addr)
                `SUBSYS_IDS_OFS: regRdData <= subsysIds;
                `WAKE_TRIGGER_OFS: regRdData <= {28'h0000000, wakeTrigger};
                `PM_CAP_OFS: regRdData <= {16'h0000, wakeCold, PM_CAP_VALUE[14:0]};
                `PM_CSR_OFS: regRdData <= {16'h0000, wakeSts, 6'h00, wakeEn, 6'h00, pmState};
                default: regRdData <= 32'h00000000;
            endcase
        end else begin
            case (regReq.addr)
                `SOCK_EVENT_OFS: regRdData <= {28'h0000000, sockEvent};
                `SOCK_MASK_OFS: regRdData <= {28'h0000000, sockMask};
                `SOCK_PRESENT_OFS: regRdData <= {20'h00000, presentBits[3:2], 4'h0, presentBits[1:0], 4'h0};
                `SOCK_CONTROL_OFS: regRdData <= {25'h0000000, sockCtl};
                `CARD_POWER_OFS: regRdData <= {24'h000000, pwrCtl};
                `STATUS_CHANGE_OFS: regRdData <= {28'h0000000, statusChange};
                `STATUS_CFG_OFS: regRdData <= {28'h0000000, statusCfg};
                `MISC_ONE_OFS: regRdData <= {24'h000000, miscOne};
                default: regRdData <= 32'h00000000;
            endcase
        end
    end

endmodule
